//--- inc/srsc_pkg.sv
// constants shared by the serial relay switch controller
package srsc_pkg;

    // ------------------------------------------------------------
    // mask layout
    // ------------------------------------------------------------
    localparam int MASK_W  = 24;
    localparam int CHAN_W  = 16;
    localparam int GND_BIT = 16;
    localparam int REF_BIT = 17;
    localparam int PAD_LSB = 18;
    localparam int USED_W  = 18;
    localparam logic [5:0] PAD_ZERO = 6'h00;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_MASK   = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;
    localparam logic [11:0] REG_LAST   = 12'h00C;
    localparam int CTRL_EN_BIT     = 0;
    localparam int CTRL_GO_BIT     = 1;
    localparam int STAT_READY_BIT  = 0;
    localparam int STAT_BUSY_BIT   = 1;
    localparam int STAT_DONE_BIT   = 2;
    localparam int STAT_PEND_BIT   = 3;
    localparam logic       EN_RESET   = 1'h0;
    localparam logic [23:0] MASK_RESET = 24'h000000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_MHZ     = 250;
    localparam int POWERUP_MS      = 10;
    localparam int POWERUP_CYCLES  = POWERUP_MS * 1000 * SYS_CLK_MHZ;
    localparam int PWR_CNT_W       = 22;
    localparam int LINK_PERIOD_NS  = 125;
    localparam int LATCH_MIN_NS    = 100;
    localparam int LATCH_TICKS     =
        (LATCH_MIN_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam logic [5:0] SCLK_LOW_TICKS  = 6'h0D;
    localparam logic [5:0] SCLK_HIGH_TICKS = 6'h1A;
    localparam logic [5:0] BIT_TICKS       = 6'h34;
    localparam logic [4:0] LAST_BIT        = 5'h17;

    // ------------------------------------------------------------
    // digital output word
    // ------------------------------------------------------------
    localparam int CTL_W       = 8;
    localparam int CTL_LATCH   = 0;
    localparam int CTL_DATA    = 1;
    localparam int CTL_SCLK    = 2;
    localparam int CTL_PWR_LSB = 3;
    localparam logic [4:0] POWER_ON = 5'h1F;

    typedef enum logic [1:0] {
        SRSC_IDLE  = 2'b00,
        SRSC_SHIFT = 2'b01,
        SRSC_LATCH = 2'b10
    } srsc_state_type;

endpackage

//--- logic/srsc_link.sv
// link-clock side: shifts one mask out and pulses the latch line
`timescale 1ns/1ps
`default_nettype none

module srsc_link (
    input  wire logic                       link_clk,
    input  wire logic                       rstn,
    input  wire logic                       req_tog,
    input  wire logic [srsc_pkg::MASK_W-1:0] mask,
    output logic                            ack_tog,
    output logic [srsc_pkg::CTL_W-1:0]       ctl_word
);

    // ------------------------------------------------------------
    // reset and request synchronisers
    // ------------------------------------------------------------
    logic rs1_q, rs2_q, lrstn;
    logic rq1_q, rq2_q, rq3_q;
    always_ff @(posedge link_clk) begin
        rs1_q <= rstn;
        rs2_q <= rs1_q;
    end
    assign lrstn = rs2_q;

    srsc_pkg::srsc_state_type st_q, st_d;
    logic [srsc_pkg::MASK_W-1:0] sreg_q, sreg_d;
    logic [4:0] bit_q, bit_d;
    logic [5:0] tick_q, tick_d;
    logic       ack_q, ack_d;
    logic [srsc_pkg::CTL_W-1:0] ctl_q, ctl_d;
    logic       sclk_d, sdat_d, lat_d;
    logic [4:0] rise_q, rise_d;
    logic [5:0] high_q, high_d;

    // ------------------------------------------------------------
    // shift sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_d   = st_q;
        sreg_d = sreg_q;
        bit_d  = bit_q;
        tick_d = tick_q + 6'h01;
        ack_d  = ack_q;
        unique case (st_q)
            srsc_pkg::SRSC_IDLE: begin
                tick_d = 6'h00;
                if (rq2_q != rq3_q) begin
                    sreg_d = mask;
                    bit_d  = srsc_pkg::LAST_BIT;
                    st_d   = srsc_pkg::SRSC_SHIFT;
                end
            end
            srsc_pkg::SRSC_SHIFT: begin
                if (tick_q == srsc_pkg::BIT_TICKS - 6'h01) begin
                    tick_d = 6'h00;
                    sreg_d = {sreg_q[srsc_pkg::MASK_W-2:0], 1'b0};
                    bit_d  = bit_q - 5'h01;
                    if (bit_q == 5'h00) begin
                        st_d = srsc_pkg::SRSC_LATCH;
                    end
                end
            end
            srsc_pkg::SRSC_LATCH: begin
                // latch one tick, >= 100 ns
                if (tick_q == 6'(srsc_pkg::LATCH_TICKS - 1)) begin
                    st_d  = srsc_pkg::SRSC_IDLE;
                    ack_d = ~ack_q;
                end
            end
            default: begin
                st_d = srsc_pkg::SRSC_IDLE;
            end
        endcase
        // bit rate link_clk/52, under 5 MHz
        // low 13, high 26, low 13 per bit
        sclk_d = (st_q == srsc_pkg::SRSC_SHIFT)
              && (tick_q >= srsc_pkg::SCLK_LOW_TICKS)
              && (tick_q < srsc_pkg::SCLK_LOW_TICKS
                          + srsc_pkg::SCLK_HIGH_TICKS);
        sdat_d = (st_q == srsc_pkg::SRSC_SHIFT) && sreg_q[srsc_pkg::MASK_W-1];
        lat_d  = (st_q == srsc_pkg::SRSC_LATCH);
        // latch, data, clock on bits 0..2
        ctl_d  = {srsc_pkg::POWER_ON, sclk_d, sdat_d, lat_d};
        rise_d = (st_q == srsc_pkg::SRSC_IDLE) ? 5'h00
               : rise_q + {4'h0, ctl_d[srsc_pkg::CTL_SCLK]
                                & ~ctl_q[srsc_pkg::CTL_SCLK]};
        high_d = ctl_q[srsc_pkg::CTL_SCLK] ? high_q + 6'h01 : 6'h00;
    end

    always_ff @(posedge link_clk) begin
        rq1_q <= req_tog;
        rq2_q <= rq1_q;
        if (!lrstn) begin
            rq3_q  <= 1'b0;
            st_q   <= srsc_pkg::SRSC_IDLE;
            sreg_q <= '0;
            bit_q  <= 5'h00;
            tick_q <= 6'h00;
            ack_q  <= 1'b0;
            ctl_q  <= {srsc_pkg::POWER_ON, 3'h0};
            rise_q <= 5'h00;
            high_q <= 6'h00;
        end else begin
            rq3_q  <= rq2_q;
            st_q   <= st_d;
            sreg_q <= sreg_d;
            bit_q  <= bit_d;
            tick_q <= tick_d;
            ack_q  <= ack_d;
            ctl_q  <= ctl_d;
            rise_q <= rise_d;
            high_q <= high_d;
        end
    end

    assign ack_tog  = ack_q;
    assign ctl_word = ctl_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_bit_count: assert property (@(posedge link_clk) disable iff (!lrstn)
        $rose(ctl_q[srsc_pkg::CTL_LATCH]) |-> rise_q == 5'h18)
        else $error("latch without exactly 24 clock rises");
    a_latch_width: assert property (@(posedge link_clk) disable iff (!lrstn)
        $rose(ctl_q[srsc_pkg::CTL_LATCH]) |=> !ctl_q[srsc_pkg::CTL_LATCH])
        else $error("latch pulse width wrong");
    a_data_hold: assert property (@(posedge link_clk) disable iff (!lrstn)
        $rose(ctl_q[srsc_pkg::CTL_SCLK]) |->
            $stable(ctl_q[srsc_pkg::CTL_DATA]) && !ctl_q[srsc_pkg::CTL_LATCH]
            ##1 $stable(ctl_q[srsc_pkg::CTL_DATA]))
        else $error("data moved at clock rise");
    a_sclk_high_len: assert property (@(posedge link_clk) disable iff (!lrstn)
        $fell(ctl_q[srsc_pkg::CTL_SCLK]) |-> high_q == srsc_pkg::SCLK_HIGH_TICKS)
        else $error("serial clock high time wrong");
    a_power_high: assert property (@(posedge link_clk) disable iff (!lrstn)
        ctl_q[srsc_pkg::CTL_W-1:srsc_pkg::CTL_PWR_LSB] == srsc_pkg::POWER_ON)
        else $error("power lines not high");

endmodule

`default_nettype wire

//--- logic/srsc_ctrl.sv
// apb-controlled host that loads relay masks into the switching headstage
`timescale 1ns/1ps
`default_nettype none

module srsc_ctrl #(
    parameter int POWERUP_CYCLES = srsc_pkg::POWERUP_CYCLES
) (
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic                        link_clk,
    input  wire logic [srsc_pkg::ADDR_W-1:0] paddr,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    output logic      [srsc_pkg::CTL_W-1:0]  ctl_word
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic                         en_q, en_d;
    logic [srsc_pkg::MASK_W-1:0]  mask_q, mask_d;
    logic [srsc_pkg::MASK_W-1:0]  hold_q, hold_d;
    logic [srsc_pkg::MASK_W-1:0]  last_q, last_d;
    logic                         pend_q, pend_d;
    logic                         done_q, done_d;
    logic                         req_q, req_d;
    logic                         ack1_q, ack2_q, ack3_q;
    logic [srsc_pkg::PWR_CNT_W-1:0] pwr_q, pwr_d;
    logic                         ready_q, ready_d;
    logic [31:0]                  rdata_q, rdata_d;
    logic                         err_q, err_d;
    logic                         ack_tog;

    logic                         setup, wr, busy, launch, fin;
    logic                         wr_ctrl, wr_mask, wr_stat, go, chg;
    logic [srsc_pkg::MASK_W-1:0]  new_mask;
    logic                         mapped;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    always_comb begin
        setup   = psel && !penable;
        wr      = psel && penable && pwrite;
        mapped  = (paddr == srsc_pkg::REG_CTRL)
               || (paddr == srsc_pkg::REG_MASK)
               || (paddr == srsc_pkg::REG_STATUS)
               || (paddr == srsc_pkg::REG_LAST);
        wr_ctrl = wr && (paddr == srsc_pkg::REG_CTRL);
        wr_mask = wr && (paddr == srsc_pkg::REG_MASK);
        wr_stat = wr && (paddr == srsc_pkg::REG_STATUS);
        go      = wr_ctrl && pwdata[srsc_pkg::CTRL_GO_BIT];
        new_mask = {srsc_pkg::PAD_ZERO, pwdata[srsc_pkg::USED_W-1:0]};
        chg      = wr_mask && (new_mask != mask_q);
    end

    // ------------------------------------------------------------
    // control registers and send scheduling
    // ------------------------------------------------------------
    always_comb begin
        busy   = (req_q != ack2_q);
        fin    = (ack2_q != ack3_q);
        // nothing sent before the power-up wait ends
        launch = pend_q && ready_q && !busy;
        en_d   = wr_ctrl ? pwdata[srsc_pkg::CTRL_EN_BIT] : en_q;
        // channel, ground and reference bits kept as written
        mask_d = wr_mask ? new_mask : mask_q;
        // a changed mask while enabled, an enable rising edge or a go write queues a resend
        pend_d = (pend_q && !launch) || go
              || (chg && (en_q || (wr_ctrl && en_d)))
              || (wr_ctrl && en_d && !en_q);
        // one whole mask handed over per send
        hold_d = launch ? mask_q : hold_q;
        req_d  = launch ? ~req_q : req_q;
        // last latched reads zero until the first send ends
        last_d = fin ? hold_q : last_q;
        // done flag: hardware set wins over write-one-clear
        done_d = fin || (done_q
              && !(wr_stat && pwdata[srsc_pkg::STAT_DONE_BIT]));
    end

    // ------------------------------------------------------------
    // power-up wait
    // ------------------------------------------------------------
    always_comb begin
        pwr_d   = pwr_q;
        ready_d = ready_q;
        // count 10 ms from reset release
        if (!ready_q) begin
            if (pwr_q == srsc_pkg::PWR_CNT_W'(POWERUP_CYCLES - 1)) begin
                ready_d = 1'b1;
            end else begin
                pwr_d = pwr_q + {{(srsc_pkg::PWR_CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // ------------------------------------------------------------
    // read data, taken in the setup cycle
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = rdata_q;
        err_d   = err_q;
        if (setup) begin
            err_d   = !mapped;
            rdata_d = 32'h00000000;
            if (paddr == srsc_pkg::REG_CTRL) begin
                rdata_d[srsc_pkg::CTRL_EN_BIT] = en_q;
            end else if (paddr == srsc_pkg::REG_MASK) begin
                rdata_d[srsc_pkg::MASK_W-1:0] = mask_q;
            end else if (paddr == srsc_pkg::REG_STATUS) begin
                rdata_d[srsc_pkg::STAT_READY_BIT] = ready_q;
                rdata_d[srsc_pkg::STAT_BUSY_BIT]  = busy;
                rdata_d[srsc_pkg::STAT_DONE_BIT]  = done_q;
                rdata_d[srsc_pkg::STAT_PEND_BIT]  = pend_q;
            end else if (paddr == srsc_pkg::REG_LAST) begin
                rdata_d[srsc_pkg::MASK_W-1:0] = last_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            en_q    <= srsc_pkg::EN_RESET;
            mask_q  <= srsc_pkg::MASK_RESET;
            hold_q  <= srsc_pkg::MASK_RESET;
            last_q  <= srsc_pkg::MASK_RESET;
            pend_q  <= 1'b0;
            done_q  <= 1'b0;
            req_q   <= 1'b0;
            ack1_q  <= 1'b0;
            ack2_q  <= 1'b0;
            ack3_q  <= 1'b0;
            pwr_q   <= '0;
            ready_q <= 1'b0;
            rdata_q <= 32'h00000000;
            err_q   <= 1'b0;
        end else begin
            en_q    <= en_d;
            mask_q  <= mask_d;
            hold_q  <= hold_d;
            last_q  <= last_d;
            pend_q  <= pend_d;
            done_q  <= done_d;
            req_q   <= req_d;
            ack1_q  <= ack_tog;
            ack2_q  <= ack1_q;
            ack3_q  <= ack2_q;
            pwr_q   <= pwr_d;
            ready_q <= ready_d;
            rdata_q <= rdata_d;
            err_q   <= err_d;
        end
    end

    assign prdata  = rdata_q;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && err_q;

    // ------------------------------------------------------------
    // link-clock shifter
    // ------------------------------------------------------------
    srsc_link u_link (
        .link_clk (link_clk),
        .rstn     (rstn),
        .req_tog  (req_q),
        .mask     (hold_q),
        .ack_tog  (ack_tog),
        .ctl_word (ctl_word)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_pad_zero: assert property (@(posedge clk) disable iff (!rstn)
        launch |=> hold_q[srsc_pkg::MASK_W-1:srsc_pkg::PAD_LSB]
                   == srsc_pkg::PAD_ZERO)
        else $error("unused mask bits not zero");
    a_no_early_send: assert property (@(posedge clk) disable iff (!rstn)
        !ready_q |-> ##1 (req_q == $past(req_q)))
        else $error("send before power-up wait");
    a_change_pend: assert property (@(posedge clk) disable iff (!rstn)
        (chg && en_q) |=> pend_q || (req_q != $past(req_q)))
        else $error("mask change not queued");
    a_one_mask: assert property (@(posedge clk) disable iff (!rstn)
        (launch ##1 busy) |=> $stable(hold_q) throughout (busy [*4]))
        else $error("mask changed while sending");
    a_send_busy: assert property (@(posedge clk) disable iff (!rstn)
        launch |=> busy && !pend_q || pend_q)
        else $error("launch did not start a send");
    a_apb_err: assert property (@(posedge clk) disable iff (!rstn)
        (setup && !mapped) |=> pslverr || !penable)
        else $error("unmapped access not flagged");
    a_last_update: assert property (@(posedge clk) disable iff (!rstn)
        fin |=> last_q == $past(hold_q))
        else $error("last mask not taken at send end");
    a_done_set: assert property (@(posedge clk) disable iff (!rstn)
        fin |=> done_q)
        else $error("done not set at send end");

endmodule

`default_nettype wire

//--- test/srsc_dev_model.sv
// behavioural model of the switching headstage on the control word
`timescale 1ns/1ps
`default_nettype none

module srsc_dev_model #(
    parameter int SETTLE_NS = 1000
) (
    input  wire logic [7:0]  ctl_word,
    output logic      [23:0] relay_q,
    output logic      [15:0] stim_sel,
    output logic             gnd_split,
    output logic             ref_float,
    output logic             settled,
    output var int           latch_cnt,
    output var int           bit_cnt,
    output var int           sclk_rises,
    output var int           viol_cnt,
    output var int           hi_ns,
    output var int           per_ns,
    output var int           lat_ns
);
    logic [23:0] shift_q;
    realtime     t_rise;
    realtime     t_lat;

    initial begin
        relay_q = 24'h000000;
        shift_q = 24'h000000;
        settled = 1'b1;
        t_rise = 0.0;
        t_lat = 0.0;
    end

    // relay meaning of the latched mask
    assign stim_sel  = relay_q[15:0];
    assign gnd_split = relay_q[16];
    assign ref_float = relay_q[17];

    // capture data on the rising serial clock
    always @(posedge ctl_word[2]) begin
        shift_q = {shift_q[22:0], ctl_word[1]};
        bit_cnt = bit_cnt + 1;
        sclk_rises = sclk_rises + 1;
        if (t_rise > 0.0) begin
            per_ns = int'($realtime - t_rise);
        end
        t_rise = $realtime;
        if (ctl_word[0]) begin
            viol_cnt = viol_cnt + 1;
        end
    end

    always @(negedge ctl_word[2]) begin
        hi_ns = int'($realtime - t_rise);
    end

    // data held while the serial clock is high
    always @(ctl_word[1]) begin
        if (ctl_word[2]) begin
            viol_cnt = viol_cnt + 1;
        end
    end

    always @(posedge ctl_word[0]) begin
        t_lat = $realtime;
    end

    // relays move only on a latch after 24 bits
    // only a fall after a real rise counts, not the power-up settle
    always @(negedge ctl_word[0]) begin
        if (t_lat > 0.0) begin
            lat_ns = int'($realtime - t_lat);
            latch_cnt = latch_cnt + 1;
            if (bit_cnt == 24) begin
                relay_q = shift_q;
                settled = 1'b0;
                settled <= #(SETTLE_NS) 1'b1;
            end
            bit_cnt = 0;
            t_lat = 0.0;
        end
    end
endmodule
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the relay switch controller and headstage model
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic        clk;
    logic        link_clk;
    logic        rstn;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  ctl_word;
    logic [23:0] relay_q;
    logic [15:0] stim_sel;
    logic        gnd_split;
    logic        ref_float;
    logic        settled;
    int          latch_cnt, bit_cnt, sclk_rises, viol_cnt;
    int          hi_ns, per_ns, lat_ns;
    int          error_cnt;
    int          n_tests;
    logic [31:0] lfsr_q;
    logic [31:0] rd;
    logic        err;
    logic [23:0] exp_q[$];
    logic [23:0] e;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        link_clk = 1'b0;
        #17.3;
        forever #62.5 link_clk = ~link_clk;
    end

    srsc_ctrl #(.POWERUP_CYCLES(20)) DUT (
        .clk(clk), .rstn(rstn), .link_clk(link_clk), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ctl_word(ctl_word));

    srsc_dev_model #(.SETTLE_NS(1000)) dev (
        .ctl_word(ctl_word), .relay_q(relay_q), .stim_sel(stim_sel),
        .gnd_split(gnd_split), .ref_float(ref_float), .settled(settled),
        .latch_cnt(latch_cnt), .bit_cnt(bit_cnt), .sclk_rises(sclk_rises),
        .viol_cnt(viol_cnt), .hi_ns(hi_ns), .per_ns(per_ns),
        .lat_ns(lat_ns));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; entered right after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (n >= 50) error_cnt++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_stat(input int b);
        int n;
        n = 0;
        do begin
            apb(1'b0, srsc_pkg::REG_STATUS, 32'h00000000);
            n++;
        end while (rd[b] !== 1'b1 && n < 30000);
        if (n >= 30000) error_cnt++;
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // compare the headstage and the last-mask register with the next expected mask
    task automatic chk_send(input int nl);
        // done can show before the latch pulse has ended
        repeat (200) begin
            if (latch_cnt < nl) @(posedge clk);
        end
        e = exp_q.pop_front();
        chk(32'(latch_cnt), 32'(nl));
        chk({31'h0, settled}, 32'h00000000);
        chk({8'h00, relay_q}, {8'h00, e});
        chk({16'h0000, stim_sel}, {16'h0000, e[15:0]});
        chk({31'h0, gnd_split}, {31'h0, e[16]});
        chk({31'h0, ref_float}, {31'h0, e[17]});
        apb(1'b0, srsc_pkg::REG_LAST, 32'h00000000);
        chk(rd, {8'h00, e});
        chk(32'(hi_ns), 32'(26 * 125));
        chk(32'(per_ns), 32'(52 * 125));
        chk(32'(lat_ns >= 100), 32'h00000001);
    endtask

    initial begin
        #380000;
        error_cnt++;
        print_verdict();
    end

    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        error_cnt = 0;
        n_tests = 0;
        lfsr_q = 32'h00001770;
        repeat (5) @(posedge clk);
        repeat (4) @(posedge link_clk);
        @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        apb(1'b0, srsc_pkg::REG_STATUS, 32'h00000000);
        chk({31'h0, rd[0]}, 32'h00000000);
        apb(1'b0, srsc_pkg::REG_MASK, 32'h00000000);
        chk(rd, 32'h00000000);
        lfsr_q = lfsr(lfsr_q);
        apb(1'b1, srsc_pkg::REG_MASK, lfsr_q & 32'hFFFCFFFF);
        apb(1'b1, srsc_pkg::REG_CTRL, 32'h00000002);
        exp_q.push_back(lfsr_q[23:0] & 24'h00FCFFFF & 24'h03FFFF);
        wait_stat(0);
        chk(32'(sclk_rises), 32'h00000000);
        chk({8'h00, relay_q}, 32'h00000000);
        chk({27'h0, ctl_word[7:3]}, {27'h0, srsc_pkg::POWER_ON});
        apb(1'b0, srsc_pkg::REG_MASK, 32'h00000000);
        chk(rd, {8'h00, exp_q[0]});
        apb(1'b1, 12'h010, lfsr_q);
        apb(1'b0, 12'h010, 32'h00000000);
        chk(rd, 32'h00000000);
        chk({31'h0, err}, 32'h00000001);
        // mid-frame: nothing latched yet, newer masks fold into one pending resend of the latest
        repeat (20000) begin
            if (bit_cnt < 12) @(posedge clk);
        end
        chk({8'h00, relay_q}, 32'h00000000);
        chk({27'h0, ctl_word[7:3]}, {27'h0, srsc_pkg::POWER_ON});
        apb(1'b1, srsc_pkg::REG_CTRL, 32'h00000001);
        lfsr_q = lfsr(lfsr_q);
        apb(1'b1, srsc_pkg::REG_MASK, lfsr_q);
        lfsr_q = lfsr(lfsr_q);
        apb(1'b1, srsc_pkg::REG_MASK, lfsr_q | 32'h00030000);
        exp_q.push_back(lfsr_q[23:0] & 24'h03FFFF | 24'h030000);
        apb(1'b0, srsc_pkg::REG_STATUS, 32'h00000000);
        chk({28'h0, rd[3:1], 1'b1}, {28'h0, 3'b101, 1'b1});
        wait_stat(2);
        chk_send(1);
        apb(1'b1, srsc_pkg::REG_STATUS, 32'h00000004);
        wait_stat(2);
        chk_send(2);
        apb(1'b0, srsc_pkg::REG_STATUS, 32'h00000000);
        chk({28'h0, rd[3:1], 1'b0}, {28'h0, 3'b010, 1'b0});
        chk(32'(viol_cnt), 32'h00000000);
        print_verdict();
    end
endmodule
`default_nettype wire
